// ===== src/bcss_defs.vh
`ifndef BCSS_DEFS_VH
`define BCSS_DEFS_VH

// Clock and times
`define BCSS_CLK_MHZ           250
`define BCSS_RST_PULSE_MS      200
`define BCSS_HOLD_MS           2000
`define BCSS_BLINK_MS          250
`define BCSS_RST_PULSE_CYC     (`BCSS_RST_PULSE_MS * 1000 * `BCSS_CLK_MHZ)
`define BCSS_HOLD_CYC          (`BCSS_HOLD_MS * 1000 * `BCSS_CLK_MHZ)
`define BCSS_BLINK_CYC         (`BCSS_BLINK_MS * 1000 * `BCSS_CLK_MHZ)

// Register byte addresses
`define BCSS_REG_CTRL          12'h000
`define BCSS_REG_STATUS        12'h004
`define BCSS_REG_CARD          12'h008
`define BCSS_REG_LAMPS         12'h00c

// Control fields
`define BCSS_CTRL_START        0
`define BCSS_CTRL_STUFF_WAIT   1
`define BCSS_CTRL_XCVR_EN      2
`define BCSS_CTRL_PROG         3

// Card register fields
`define BCSS_CARD_CHECKED      0
`define BCSS_CARD_FORMAT_OK    1
`define BCSS_CARD_MAIN_FILE    2

// Mode switch value for fast passive parallel
`define BCSS_MODE_FPP          2'h1

// Progress codes on the three low processor lamps
`define BCSS_PROG_F            3'h1
`define BCSS_PROG_A            3'h2
`define BCSS_PROG_E            3'h3
`define BCSS_PROG_B            3'h4
`define BCSS_PROG_D            3'h5

// AXI responses
`define BCSS_RESP_OKAY         2'h0
`define BCSS_RESP_SLVERR       2'h2

`endif

// ===== src/bcss_button_reset.v
`timescale 1ns/1ns
`include "bcss_defs.vh"

module bcss_button_reset #(
    parameter PULSE_CYC = `BCSS_RST_PULSE_CYC,
    parameter HOLD_CYC  = `BCSS_HOLD_CYC
) (
    input  wire clk,        // Board clock
    input  wire rst_n,      // Synchronous reset, active low
    input  wire button,     // Reset button, high while pressed
    input  wire undervolt,  // Any rail below threshold
    output wire reset_n     // Board reset line, active low
);
    reg [31:0] pulse_q;
    reg [31:0] hold_q;
    reg        held_q;

    always @(posedge clk) begin
        if (!rst_n) begin
            pulse_q <= 32'h0;
            hold_q  <= 32'h0;
            held_q  <= 1'b0;
        end else begin
            if (button) begin
                if (hold_q != HOLD_CYC[31:0] - 32'h1)
                    hold_q <= hold_q + 32'h1;
                else
                    held_q <= 1'b1;
            end else begin
                hold_q <= 32'h0;
                held_q <= 1'b0;
            end
            if (button && hold_q == 32'h0)
                pulse_q <= PULSE_CYC[31:0];
            else if (pulse_q != 32'h0)
                pulse_q <= pulse_q - 32'h1;
        end
    end

    assign reset_n = !(pulse_q != 32'h0 || held_q || undervolt);
endmodule

// ===== src/bcss_top.v
`timescale 1ns/1ns
`include "bcss_defs.vh"

module bcss_top #(
    parameter PULSE_CYC = `BCSS_RST_PULSE_CYC,
    parameter HOLD_CYC  = `BCSS_HOLD_CYC,
    parameter BLINK_CYC = `BCSS_BLINK_CYC
) (
    input  wire        MCLK,                     // 250 MHz board clock
    input  wire        RESETN,                   // Power-up reset, active low
    input  wire        RESET_BUTTON,             // Button pressed, high
    input  wire        UNDERVOLT,                // Rail undervoltage, high
    input  wire [1:0]  CONFIG_MODE_SWITCHES,     // Loading mode switches
    input  wire        CARD_PRESENT,             // Card in socket
    input  wire        PLL_A_LOCK,               // First synthesizer locked
    input  wire        PLL_B_LOCK,               // Second synthesizer locked
    input  wire        FPGA_DONE,                // Target reports configured
    input  wire        HOST_RESET_N,             // Host bus reset, active low
    output reg         BOARD_RESET_LINE_N,       // Board reset line, active low
    output reg         PROC_RESET_N,             // Processor reset, active low
    output reg         FPGA_CLEAR_N,             // Clears FPGA config, active low
    output reg  [2:0]  FPGA_SELECT,              // FPGA being loaded, progress code
    output reg         FPGA_LOAD,                // Load strobe level to target
    output reg         XCVR_ENABLE,              // Serial transceiver enable
    output reg         MAIN_MENU,                // Main menu shown
    output reg         PROC_LAMP_CFG_DONE,       // Highest processor lamp
    output reg  [2:0]  PROC_LAMP_PROGRESS,       // Three low processor lamps
    output reg         CPLD_LAMP_UNCONFIGURED,   // Highest support lamp
    output reg         CPLD_LAMP_RESET_ACTIVE,   // Second-highest support lamp
    output reg         CPLD_LAMP_PLL_A_LOCK,     // Second-lowest support lamp
    output reg         CPLD_LAMP_PLL_B_LOCK,     // Lowest support lamp
    input  wire [11:0] AWADDR,                   // AXI write address
    input  wire        AWVALID,                  // AXI
    output wire        AWREADY,                  // AXI
    input  wire [31:0] WDATA,                    // AXI write data
    input  wire [3:0]  WSTRB,                    // AXI byte strobes
    input  wire        WVALID,                   // AXI
    output wire        WREADY,                   // AXI
    output reg  [1:0]  BRESP,                    // AXI write response
    output reg         BVALID,                   // AXI
    input  wire        BREADY,                   // AXI
    input  wire [11:0] ARADDR,                   // AXI read address
    input  wire        ARVALID,                  // AXI
    output wire        ARREADY,                  // AXI
    output reg  [31:0] RDATA,                    // AXI read data
    output reg  [1:0]  RRESP,                    // AXI read response
    output reg         RVALID,                   // AXI
    input  wire        RREADY                    // AXI
);
    localparam S_IDLE  = 3'h0;
    localparam S_CLEAR = 3'h1;
    localparam S_CHECK = 3'h2;
    localparam S_LOAD  = 3'h3;
    localparam S_WAIT  = 3'h4;
    localparam S_MENU  = 3'h5;

    wire       btn_rst_n;
    reg  [2:0] state_q;
    reg  [2:0] idx_q;
    reg        cfg_ok_q;
    reg        start_q;
    reg        stuff_wait_q;
    reg        xcvr_en_q;
    reg        prog_q;
    reg  [2:0] card_q;
    reg        done_q;
    reg        blink_q;
    reg [31:0] blink_cnt_q;
    reg        aw_hold_q;
    reg        w_hold_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q;
    reg  [3:0] wstrb_q;

    wire board_rst_n = btn_rst_n & RESETN;

    function [2:0] prog_code;
        input [2:0] idx;
        begin
            case (idx)
                3'h0:    prog_code = `BCSS_PROG_F;
                3'h1:    prog_code = `BCSS_PROG_A;
                3'h2:    prog_code = `BCSS_PROG_E;
                3'h3:    prog_code = `BCSS_PROG_B;
                default: prog_code = `BCSS_PROG_D;
            endcase
        end
    endfunction

    function card_valid;
        input [2:0] card;
        begin
            card_valid = card[`BCSS_CARD_CHECKED] & card[`BCSS_CARD_FORMAT_OK]
                       & card[`BCSS_CARD_MAIN_FILE];
        end
    endfunction

    bcss_button_reset #(
        .PULSE_CYC (PULSE_CYC),
        .HOLD_CYC  (HOLD_CYC)
    ) u_btn (
        .clk       (MCLK),
        .rst_n     (RESETN),
        .button    (RESET_BUTTON),
        .undervolt (UNDERVOLT),
        .reset_n   (btn_rst_n)
    );

    // Power-up and button reset both enter the same sequence
    always @(posedge MCLK) begin
        if (!board_rst_n) begin
            state_q      <= S_CLEAR;
            idx_q        <= 3'h0;
            cfg_ok_q     <= 1'b0;
            FPGA_CLEAR_N <= 1'b0;
            FPGA_LOAD    <= 1'b0;
            FPGA_SELECT  <= 3'h0;
            MAIN_MENU    <= 1'b0;
        end else begin
            case (state_q)
                S_CLEAR: begin
                    FPGA_CLEAR_N <= 1'b1;
                    state_q      <= S_CHECK;
                end
                S_CHECK: begin
                    if (!CARD_PRESENT || (card_q[`BCSS_CARD_CHECKED]
                                          && !card_valid(card_q))) begin
                        state_q <= S_MENU;
                    end else if (card_valid(card_q)) begin
                        if (CONFIG_MODE_SWITCHES == `BCSS_MODE_FPP) begin
                            state_q     <= S_LOAD;
                            FPGA_SELECT <= prog_code(3'h0);
                        end else begin
                            state_q <= S_MENU;
                        end
                    end
                end
                S_LOAD: begin
                    FPGA_LOAD <= 1'b1;
                    state_q   <= S_WAIT;
                end
                S_WAIT: begin
                    FPGA_LOAD <= 1'b0;
                    if (FPGA_DONE && !FPGA_LOAD) begin  // Done may still be the last FPGA's
                        if (idx_q == 3'h4) begin
                            cfg_ok_q <= 1'b1;
                            state_q  <= S_MENU;
                        end else begin
                            idx_q       <= idx_q + 3'h1;
                            FPGA_SELECT <= prog_code(idx_q + 3'h1);
                            state_q     <= S_LOAD;
                        end
                    end
                end
                S_MENU: begin
                    MAIN_MENU <= 1'b1;
                    if (start_q) begin
                        state_q      <= S_CLEAR;
                        FPGA_CLEAR_N <= 1'b0;
                        MAIN_MENU    <= 1'b0;
                        idx_q        <= 3'h0;
                        cfg_ok_q     <= 1'b0;
                    end
                end
                default: state_q <= S_CLEAR;
            endcase
        end
    end

    always @(posedge MCLK) begin
        if (!board_rst_n) begin
            blink_cnt_q <= 32'h0;
            blink_q     <= 1'b0;
            done_q      <= 1'b0;
        end else begin
            done_q <= FPGA_DONE;
            if (blink_cnt_q == BLINK_CYC[31:0] - 32'h1) begin
                blink_cnt_q <= 32'h0;
                blink_q     <= !blink_q;
            end else begin
                blink_cnt_q <= blink_cnt_q + 32'h1;
            end
        end
    end

    // Lamps held in registers, cleared by board reset except the reset and unconfigured lamps, which board reset lights
    always @(posedge MCLK) begin
        if (!board_rst_n) begin
            PROC_LAMP_CFG_DONE     <= 1'b0;
            PROC_LAMP_PROGRESS     <= 3'h0;
            CPLD_LAMP_UNCONFIGURED <= 1'b1;
            CPLD_LAMP_RESET_ACTIVE <= 1'b1;
            CPLD_LAMP_PLL_A_LOCK   <= 1'b0;
            CPLD_LAMP_PLL_B_LOCK   <= 1'b0;
        end else begin
            PROC_LAMP_CFG_DONE     <= cfg_ok_q;
            if (state_q == S_LOAD || state_q == S_WAIT)
                PROC_LAMP_PROGRESS <= FPGA_SELECT;
            else if (stuff_wait_q || (!card_valid(card_q) && done_q))
                PROC_LAMP_PROGRESS <= {3{blink_q}};
            else
                PROC_LAMP_PROGRESS <= 3'h0;
            CPLD_LAMP_UNCONFIGURED <= !done_q;
            CPLD_LAMP_RESET_ACTIVE <= 1'b0;
            CPLD_LAMP_PLL_A_LOCK   <= PLL_A_LOCK;
            CPLD_LAMP_PLL_B_LOCK   <= PLL_B_LOCK;
        end
    end

    always @(posedge MCLK) begin
        if (!RESETN) begin
            BOARD_RESET_LINE_N <= 1'b0;
            PROC_RESET_N       <= 1'b0;
            XCVR_ENABLE        <= 1'b0;
        end else begin
            BOARD_RESET_LINE_N <= btn_rst_n;
            PROC_RESET_N       <= btn_rst_n;
            XCVR_ENABLE        <= xcvr_en_q && !prog_q;
        end
    end

    // AXI4-Lite slave
    wire have_aw = aw_hold_q | AWVALID;
    wire have_w  = w_hold_q | WVALID;
    wire [11:0] wa = aw_hold_q ? awaddr_q : AWADDR;
    wire [31:0] wd = w_hold_q ? wdata_q : WDATA;
    wire [3:0]  ws = w_hold_q ? wstrb_q : WSTRB;
    wire do_wr = have_aw && have_w && !BVALID;

    assign AWREADY = !aw_hold_q && !BVALID;
    assign WREADY  = !w_hold_q && !BVALID;
    assign ARREADY = !RVALID;

    always @(posedge MCLK) begin
        if (!RESETN) begin
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
            awaddr_q     <= 12'h0;
            wdata_q      <= 32'h0;
            wstrb_q      <= 4'h0;
            BVALID       <= 1'b0;
            BRESP        <= `BCSS_RESP_OKAY;
            RVALID       <= 1'b0;
            RRESP        <= `BCSS_RESP_OKAY;
            RDATA        <= 32'h0;
            start_q      <= 1'b0;
            stuff_wait_q <= 1'b0;
            xcvr_en_q    <= 1'b0;
            prog_q       <= 1'b0;
            card_q       <= 3'h0;
        end else begin
            start_q <= 1'b0;
            if (!CARD_PRESENT)
                card_q <= 3'h0;
            if (do_wr) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                BVALID    <= 1'b1;
                BRESP     <= `BCSS_RESP_OKAY;
                if (wa == `BCSS_REG_CTRL && ws[0]) begin
                    start_q      <= wd[`BCSS_CTRL_START];
                    stuff_wait_q <= wd[`BCSS_CTRL_STUFF_WAIT];
                    xcvr_en_q    <= wd[`BCSS_CTRL_XCVR_EN];
                    prog_q       <= wd[`BCSS_CTRL_PROG];
                end else if (wa == `BCSS_REG_CARD && ws[0]) begin
                    if (CARD_PRESENT)
                        card_q <= wd[2:0];
                end else if (wa != `BCSS_REG_CTRL && wa != `BCSS_REG_CARD) begin
                    BRESP <= `BCSS_RESP_SLVERR;
                end
            end else begin
                if (AWVALID && AWREADY) begin
                    aw_hold_q <= 1'b1;
                    awaddr_q  <= AWADDR;
                end
                if (WVALID && WREADY) begin
                    w_hold_q <= 1'b1;
                    wdata_q  <= WDATA;
                    wstrb_q  <= WSTRB;
                end
            end
            if (BVALID && BREADY)
                BVALID <= 1'b0;
            if (ARVALID && ARREADY) begin
                RVALID <= 1'b1;
                RRESP  <= `BCSS_RESP_OKAY;
                case (ARADDR)
                    `BCSS_REG_CTRL:   RDATA <= {28'h0, prog_q, xcvr_en_q, stuff_wait_q, 1'b0};
                    `BCSS_REG_STATUS: RDATA <= {22'h0, !HOST_RESET_N, done_q, MAIN_MENU,
                                                cfg_ok_q, idx_q, state_q};
                    `BCSS_REG_CARD:   RDATA <= {28'h0, CARD_PRESENT, card_q};
                    `BCSS_REG_LAMPS:  RDATA <= {24'h0, CPLD_LAMP_PLL_B_LOCK,
                                                CPLD_LAMP_PLL_A_LOCK,
                                                CPLD_LAMP_RESET_ACTIVE,
                                                CPLD_LAMP_UNCONFIGURED,
                                                PROC_LAMP_PROGRESS, PROC_LAMP_CFG_DONE};
                    default: begin
                        RDATA <= 32'h0;
                        RRESP <= `BCSS_RESP_SLVERR;
                    end
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end
        end
    end
endmodule

// ===== testbench/bcss_top_sva.sv
`timescale 1ns/1ns
`include "bcss_defs.vh"
module bcss_top_sva (
    input wire        MCLK,                   // Clock
    input wire        RESETN,                 // Reset
    input wire        UNDERVOLT,              // Rail low
    input wire [1:0]  CONFIG_MODE_SWITCHES,   // Mode
    input wire        CARD_PRESENT,           // Card in
    input wire        PLL_A_LOCK,             // Lock A
    input wire        PLL_B_LOCK,             // Lock B
    input wire        FPGA_DONE,              // Target done
    input wire        BOARD_RESET_LINE_N,     // Board reset
    input wire        FPGA_CLEAR_N,           // Clear
    input wire [2:0]  FPGA_SELECT,            // Code
    input wire        FPGA_LOAD,              // Load pulse
    input wire        XCVR_ENABLE,            // Transceiver
    input wire        MAIN_MENU,              // Menu
    input wire        PROC_LAMP_CFG_DONE,     // Lamp
    input wire [2:0]  PROC_LAMP_PROGRESS,     // Lamps
    input wire        CPLD_LAMP_UNCONFIGURED, // Lamp
    input wire        CPLD_LAMP_RESET_ACTIVE, // Lamp
    input wire        CPLD_LAMP_PLL_A_LOCK,   // Lamp
    input wire        CPLD_LAMP_PLL_B_LOCK,   // Lamp
    input wire [11:0] AWADDR,                 // AXI
    input wire        AWVALID,                // AXI
    input wire        AWREADY,                // AXI
    input wire [31:0] WDATA,                  // AXI
    input wire        WVALID,                 // AXI
    input wire        WREADY,                 // AXI
    input wire        BVALID                  // AXI
);
    reg prog_q;
    wire wr_hs = AWVALID && AWREADY && WVALID && WREADY;

    // Mirror of the processor programming bit
    always @(posedge MCLK) begin
        if (!RESETN)
            prog_q <= 1'h0;
        else if (wr_hs && AWADDR == `BCSS_REG_CTRL)
            prog_q <= WDATA[`BCSS_CTRL_PROG];
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    sequence s_line_up3;
        BOARD_RESET_LINE_N [*3];
    endsequence
    sequence s_code_legal;
        FPGA_SELECT >= 3'h1 && FPGA_SELECT <= 3'h5;
    endsequence

    a_clear_on_reset: assert property (!BOARD_RESET_LINE_N |-> ##[0:1] !FPGA_CLEAR_N)
        else $error("clear not driven in board reset");
    a_no_load_clear: assert property (FPGA_LOAD |-> FPGA_CLEAR_N && BOARD_RESET_LINE_N)
        else $error("load during clear");
    a_load_needs_mode: assert property (FPGA_LOAD |->
        CARD_PRESENT && CONFIG_MODE_SWITCHES == `BCSS_MODE_FPP)
        else $error("load without card or mode");
    a_menu_not_loading: assert property (FPGA_LOAD |-> !MAIN_MENU)
        else $error("menu shown during load");
    a_cfg_done_lamp: assert property ($rose(PROC_LAMP_CFG_DONE) |-> FPGA_DONE)
        else $error("done lamp without done");
    a_progress_code: assert property (FPGA_LOAD |->
        s_code_legal ##[1:3] PROC_LAMP_PROGRESS == FPGA_SELECT)
        else $error("progress lamps wrong");
    a_unconfig_lamp: assert property (s_line_up3 |->
        CPLD_LAMP_UNCONFIGURED == !$past(FPGA_DONE, 2))
        else $error("unconfigured lamp wrong");
    a_reset_lamp_on: assert property ($fell(BOARD_RESET_LINE_N) |-> ##[0:1] CPLD_LAMP_RESET_ACTIVE)
        else $error("reset lamp not lit");
    a_reset_lamp_off: assert property (s_line_up3 |-> !CPLD_LAMP_RESET_ACTIVE)
        else $error("reset lamp lit out of reset");
    a_pll_a_lamp: assert property ((PLL_A_LOCK && BOARD_RESET_LINE_N) [*4] |-> CPLD_LAMP_PLL_A_LOCK)
        else $error("lock A lamp dark");
    a_pll_b_dark: assert property ((!PLL_B_LOCK) [*3] |-> !CPLD_LAMP_PLL_B_LOCK)
        else $error("lock B lamp lit");
    a_xcvr_prog_off: assert property (prog_q && $past(prog_q) |-> !XCVR_ENABLE)
        else $error("transceiver on while programming");
    a_undervolt_line: assert property (UNDERVOLT |-> ##[1:3] !BOARD_RESET_LINE_N)
        else $error("undervolt without reset");
    a_write_answer: assert property (wr_hs |=> BVALID)
        else $error("no write response");
endmodule

bind bcss_top bcss_top_sva i_bcss_top_sva (.*);

// ===== testbench/bcss_fpga_model.sv
`timescale 1ns/1ns
module bcss_fpga_model (
    input  wire      clk,           // Board clock
    input  wire      clear_n,       // Clear configuration, active low
    input  wire      load,          // Start of one FPGA load
    output reg       done = 1'h0    // Current FPGA configured
);
    reg [3:0] cnt_q  = 4'h0;
    reg       busy_q = 1'h0;
    reg       slow_q = 1'h0;

    // Loads alternate between a quick and a slow finish
    always @(posedge clk) begin
        if (!clear_n) begin
            done   <= 1'h0;
            busy_q <= 1'h0;
        end else if (load) begin
            done   <= 1'h0;
            busy_q <= 1'h1;
            cnt_q  <= slow_q ? 4'hc : 4'h3;
            slow_q <= !slow_q;
        end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                done   <= 1'h1;
                busy_q <= 1'h0;
            end
        end
    end
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
`include "bcss_defs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    localparam PULSE = 20;
    logic MCLK = 1'h0, RESETN = 1'h0, RESET_BUTTON = 1'h0, UNDERVOLT = 1'h0, CARD_PRESENT = 1'h0;
    logic PLL_A_LOCK = 1'h0, PLL_B_LOCK = 1'h0, HOST_RESET_N = 1'h0;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
    logic [1:0] CONFIG_MODE_SWITCHES = 2'h1, BRESP, RRESP;
    logic [11:0] AWADDR = 12'h0, ARADDR = 12'h0;
    logic [3:0] WSTRB = 4'hf;
    logic [31:0] WDATA = 32'h0, RDATA;
    wire BOARD_RESET_LINE_N, PROC_RESET_N, FPGA_CLEAR_N, FPGA_LOAD, XCVR_ENABLE, MAIN_MENU;
    wire PROC_LAMP_CFG_DONE, CPLD_LAMP_UNCONFIGURED, CPLD_LAMP_RESET_ACTIVE, FPGA_DONE;
    wire CPLD_LAMP_PLL_A_LOCK, CPLD_LAMP_PLL_B_LOCK, AWREADY, WREADY, BVALID, ARREADY, RVALID;
    wire [2:0] FPGA_SELECT, PROC_LAMP_PROGRESS;
    logic [2:0] codes[$];
    logic [2:0] order[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
    integer checks = 0, failures = 0, cyc = 0;

    bcss_top #(.PULSE_CYC(PULSE), .HOLD_CYC(100), .BLINK_CYC(4)) i_bcss_top (.*);
    bcss_fpga_model i_bcss_fpga_model (.clk(MCLK), .clear_n(FPGA_CLEAR_N), .load(FPGA_LOAD),
        .done(FPGA_DONE));

    always #2 MCLK = ~MCLK;
    always @(posedge MCLK) if (FPGA_LOAD === 1'h1) codes.push_back(FPGA_SELECT);
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            $display("unexpected timeout expected 0 seen 1");
            summarize;
        end
    end

    task summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Everything runs 1 ns after the edge, so outputs are settled
    task tk(input integer n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task wr(input [11:0] a, input [31:0] d, output [1:0] r);
        logic aw, w, b;
        begin
            AWADDR <= a; WDATA <= d; AWVALID <= 1'h1; WVALID <= 1'h1; BREADY <= 1'h1;
            b = 1'h0;
            while (!b) begin
                #1;
                aw = AWREADY & AWVALID; w = WREADY & WVALID; b = BVALID; r = BRESP;
                tk(1);
                if (aw) AWVALID <= 1'h0;
                if (w) WVALID <= 1'h0;
            end
            BREADY <= 1'h0;
        end
    endtask
    task rd(input [11:0] a, output [31:0] d, output [1:0] r);
        logic ar, v;
        begin
            ARADDR <= a; ARVALID <= 1'h1; RREADY <= 1'h1;
            v = 1'h0;
            while (!v) begin
                #1;
                ar = ARREADY & ARVALID; v = RVALID; d = RDATA; r = RRESP;
                tk(1);
                if (ar) ARVALID <= 1'h0;
            end
            RREADY <= 1'h0;
        end
    endtask
    task do_reset;
        RESETN <= 1'h0;
        codes.delete();
        tk(8);
        `CHK("unconfig lamp", 1'h1, CPLD_LAMP_UNCONFIGURED)
        `CHK("reset lamp", 1'h1, CPLD_LAMP_RESET_ACTIVE)
        `CHK("cfg lamp", 1'h0, PROC_LAMP_CFG_DONE)
        `CHK("clear", 1'h0, FPGA_CLEAR_N)
        RESETN <= 1'h1;
    endtask
    task wait_line;
        integer n;
        for (n = 0; n < 300 && BOARD_RESET_LINE_N !== 1'h1; n++) tk(1);
        codes.delete();
    endtask
    task wait_menu;
        integer n;
        for (n = 0; n < 3000 && MAIN_MENU !== 1'h1; n++) tk(1);
        tk(3);
        `CHK("menu", 1'h1, MAIN_MENU)
    endtask
    task chk_loads;
        integer i;
        `CHK("load count", 5, codes.size())
        for (i = 0; i < 5 && i < codes.size(); i++) `CHK("fpga code", order[i], codes[i])
        `CHK("cfg lamp", 1'h1, PROC_LAMP_CFG_DONE)
        `CHK("unconfig lamp", 1'h0, CPLD_LAMP_UNCONFIGURED)
    endtask
    task t_skip(input [1:0] m, input p, input [31:0] c);
        logic [1:0] r;
        CONFIG_MODE_SWITCHES <= m; CARD_PRESENT <= p;
        do_reset;
        tk(2);
        wr(`BCSS_REG_CARD, c, r);
        wait_menu;
        `CHK("loads", 0, codes.size())
        `CHK("unconfig lamp", 1'h1, CPLD_LAMP_UNCONFIGURED)
        `CHK("cfg lamp", 1'h0, PROC_LAMP_CFG_DONE)
        $display("t_skip done");
    endtask
    task t_load;
        logic [1:0] r;
        CONFIG_MODE_SWITCHES <= `BCSS_MODE_FPP; CARD_PRESENT <= 1'h1;
        do_reset;
        tk(10);
        `CHK("loads before check", 0, codes.size())
        wr(`BCSS_REG_CARD, 32'h7, r);
        wait_menu;
        chk_loads;
        `CHK("progress idle", 3'h0, PROC_LAMP_PROGRESS)
        $display("t_load done");
    endtask
    task t_regs;
        logic [1:0] r;
        logic [31:0] d;
        logic ok, s7, s0;
        integer i;
        HOST_RESET_N <= 1'h1;
        wr(`BCSS_REG_CTRL, 32'hc, r); tk(3);
        `CHK("xcvr prog", 1'h0, XCVR_ENABLE)
        wr(`BCSS_REG_CTRL, 32'h4, r); tk(3);
        `CHK("xcvr on", 1'h1, XCVR_ENABLE)
        wr(`BCSS_REG_CTRL, 32'h2, r);
        ok = 1'h1; s7 = 1'h0; s0 = 1'h0;
        for (i = 0; i < 24; i++) begin
            if (PROC_LAMP_PROGRESS !== 3'h0 && PROC_LAMP_PROGRESS !== 3'h7) ok = 1'h0;
            if (PROC_LAMP_PROGRESS === 3'h7) s7 = 1'h1;
            if (PROC_LAMP_PROGRESS === 3'h0) s0 = 1'h1;
            tk(1);
        end
        `CHK("blink", 1'h1, ok && s7 && s0)
        wr(`BCSS_REG_CTRL, 32'h0, r);
        rd(12'h010, d, r);
        `CHK("unmapped rresp", `BCSS_RESP_SLVERR, r)
        `CHK("unmapped rdata", 32'h0, d)
        wr(12'h010, 32'h1, r);
        `CHK("unmapped bresp", `BCSS_RESP_SLVERR, r)
        rd(`BCSS_REG_STATUS, d, r);
        `CHK("status menu", 1'h1, d[7])
        `CHK("status host", 1'h0, d[9])
        codes.delete();
        wr(`BCSS_REG_CTRL, 32'h1, r);
        tk(3);
        `CHK("menu on restart", 1'h0, MAIN_MENU)
        wait_menu;
        chk_loads;
        $display("t_regs done");
    endtask
    task t_pll;
        PLL_A_LOCK <= 1'h1; PLL_B_LOCK <= 1'h0; tk(6);
        `CHK("lock A lamp", 1'h1, CPLD_LAMP_PLL_A_LOCK)
        `CHK("lock B lamp", 1'h0, CPLD_LAMP_PLL_B_LOCK)
        PLL_A_LOCK <= 1'h0; PLL_B_LOCK <= 1'h1; tk(6);
        `CHK("lock A lamp", 1'h0, CPLD_LAMP_PLL_A_LOCK)
        `CHK("lock B lamp", 1'h1, CPLD_LAMP_PLL_B_LOCK)
        $display("t_pll done");
    endtask
    task t_button;
        integer n;
        RESET_BUTTON <= 1'h1; tk(1);
        RESET_BUTTON <= 1'h0;
        for (n = 0; n < 10 && BOARD_RESET_LINE_N !== 1'h0; n++) tk(1);
        for (n = 0; n < 200 && BOARD_RESET_LINE_N === 1'h0; n++) begin
            if (n == 5) begin
                `CHK("proc reset", 1'h0, PROC_RESET_N)
                `CHK("clear", 1'h0, FPGA_CLEAR_N)
                `CHK("menu in reset", 1'h0, MAIN_MENU)
                `CHK("reset lamp", 1'h1, CPLD_LAMP_RESET_ACTIVE)
            end
            tk(1);
        end
        `CHK("pulse length", 1'h1, n >= PULSE && n <= PULSE + 2)
        codes.delete();
        wait_menu;
        chk_loads;
        RESET_BUTTON <= 1'h1; tk(150);
        `CHK("held line", 1'h0, BOARD_RESET_LINE_N)
        RESET_BUTTON <= 1'h0;
        wait_line;
        wait_menu;
        UNDERVOLT <= 1'h1; tk(4);
        `CHK("undervolt line", 1'h0, BOARD_RESET_LINE_N)
        `CHK("reset lamp", 1'h1, CPLD_LAMP_RESET_ACTIVE)
        UNDERVOLT <= 1'h0;
        wait_line;
        wait_menu;
        chk_loads;
        $display("t_button done");
    endtask

    initial begin
        t_skip(`BCSS_MODE_FPP, 1'h0, 32'h7);
        t_skip(`BCSS_MODE_FPP, 1'h1, 32'h3);
        t_skip(`BCSS_MODE_FPP, 1'h1, 32'h5);
        t_skip(`BCSS_MODE_FPP, 1'h1, 32'h1);
        t_skip(2'h0, 1'h1, 32'h7);
        t_load;
        t_regs;
        t_pll;
        t_button;
        summarize;
    end
endmodule
